// >>> verilog/ebc_params.svh
// Constants for the external bus control and hold block.
`ifndef EBC_PARAMS_SVH
`define EBC_PARAMS_SVH
// What this block does
// - Data strobe low in data and wait states, high while idle.
// - Address latch strobe falls mid address state, rises mid final state.
// - Status code: 00 idle, 01 branch fetch, 10 operand, 11 sequential fetch.
// - Status changes only at rising edge of address and idle states.
// - First fetch after reset or interrupt start reports branch fetch.
// - After reset status pins are port pins and show no status.
// - Port 10 has four pins, each direction set by its direction register.
// - Port 10 byte writes drop upper nibble; upper nibble of port 10 reads is zero.
// - Pins 0 and 1 carry hold grant and request when function enabled.
// - Hold request is synchronised; running cycle finishes, then bus floats.
// - With no cycle running, hold request floats the bus at once.
// - Grant follows floating; bus stays floating while grant is active.
// - Clock output runs always; inhibit bit forces it to zero.
// - Clock source select pin is only synchronised and shown in the status register.
// - Wait sampled at falling edge of data and wait states adds a state.
// - Mode pins: 00 ROM-less, 10 single-chip, 11 PROM, 01 reserved.
// - Low asynchronous reset starts reset and leaves standby.
// - Address/data pins: low address, then 16-bit data, float while idle.
// - Read/write high for read, low for write, high when idle.
// - Byte enables low for word and half; byte selects by address bit 0.

// ********************************************************************
// Register offsets
// ********************************************************************
`define EBC_REG_PSC 3'h0
`define EBC_REG_CTRL 3'h1
`define EBC_REG_P10_DATA 3'h2
`define EBC_REG_P10_DIR 3'h3
`define EBC_REG_P10_FSEL 3'h4
`define EBC_REG_STATUS 3'h5

// ********************************************************************
// Fields and codes
// ********************************************************************
`define EBC_PSC_CLK_INHIBIT 0
`define EBC_PSC_STANDBY 1
`define EBC_CTRL_EXT_EN 0
`define EBC_CTRL_STATUS_EN 1
`define EBC_P10_DIR_RESET 4'hF
`define EBC_PIN_GRANT 0
`define EBC_PIN_REQUEST 1
`define EBC_MODE_ROMLESS 2'h0
`define EBC_ST_IDLE 2'h0
`define EBC_ST_BRANCH 2'h1
`define EBC_SIZE_BYTE 2'h0
`define EBC_SYNC_WIDTH 24
`endif

// >>> verilog/ebc_pkg.sv
// Types shared by the external bus control and hold block.
package ebc_pkg;
  typedef enum logic [2:0] {
    EBC_IDLE,
    EBC_ADDR,
    EBC_DATA,
    EBC_WAIT,
    EBC_FINAL
  } ebc_bus_t;

  typedef enum logic [1:0] {
    EBC_H_OFF,
    EBC_H_FLOAT,
    EBC_H_ON,
    EBC_H_LEAVE
  } ebc_hold_t;
endpackage : ebc_pkg

// >>> verilog/ebc_sync.sv
// Two-stage synchroniser for pins that arrive from outside the clock.
`timescale 1ns/1ps
module ebc_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } ebc_sync_state_t;

  ebc_sync_state_t s;
  ebc_sync_state_t next_s;

  always_comb begin
    next_s.first = din;
    next_s.second = s.first;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.second;
endmodule : ebc_sync

// >>> verilog/ebc_port10.sv
// Four-pin port with hold request and hold grant sharing its two low pins.
`timescale 1ns/1ps
`include "ebc_params.svh"
module ebc_port10 (
  input wire logic clock,
  input wire logic resetn,
  input wire logic wr_data,
  input wire logic wr_dir,
  input wire logic wr_fsel,
  input wire logic [3:0] wdata,
  input wire logic [3:0] pin_sync,
  input wire logic grant,
  output logic [3:0] read_value,
  output logic [3:0] dir,
  output logic [3:0] fsel,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe_n,
  output logic hold_req
);
  typedef struct packed {
    logic [3:0] latch;
    logic [3:0] dir;
    logic [1:0] fsel;
    logic [3:0] out;
    logic [3:0] oe_n;
  } ebc_p10_state_t;

  ebc_p10_state_t s;
  ebc_p10_state_t next_s;

  always_comb begin
    next_s = s;
    if (wr_data) next_s.latch = wdata;
    if (wr_dir) next_s.dir = wdata;
    if (wr_fsel) next_s.fsel = wdata[1:0];
    next_s.out = next_s.latch;
    next_s.oe_n = next_s.dir;
    if (next_s.fsel[`EBC_PIN_GRANT]) begin
      next_s.out[`EBC_PIN_GRANT] = grant;
      next_s.oe_n[`EBC_PIN_GRANT] = 1'b0;
    end
    if (next_s.fsel[`EBC_PIN_REQUEST]) next_s.oe_n[`EBC_PIN_REQUEST] = 1'b1;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.dir <= `EBC_P10_DIR_RESET;
      s.oe_n <= 4'hF;
    end else begin
      s <= next_s;
    end
  end

  assign read_value = (s.dir & pin_sync) | (~s.dir & s.latch);
  assign dir = s.dir;
  assign fsel = {2'h0, s.fsel};
  assign pin_out = s.out;
  assign pin_oe_n = s.oe_n;
  assign hold_req = s.fsel[`EBC_PIN_REQUEST] & pin_sync[`EBC_PIN_REQUEST];
endmodule : ebc_port10

// >>> verilog/ebc_top.sv
// External bus sequencer with strobes, status, waits and bus hold.
`timescale 1ns/1ps
`include "ebc_params.svh"
module ebc_top (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic core_req,
  input wire logic core_write,
  input wire logic [23:0] core_addr,
  input wire logic [1:0] core_size,
  input wire logic [1:0] core_kind,
  input wire logic [15:0] core_wdata,
  input wire logic core_irq_begin,
  output logic core_accept,
  output logic [15:0] core_rdata,
  output logic core_rvalid,
  input wire logic [15:0] muxed_addr_data_in,
  output logic [15:0] muxed_addr_data_out,
  output logic muxed_addr_data_oe_n,
  output logic [7:0] addr_high_out,
  output logic addr_high_oe_n,
  output logic data_strobe_n,
  output logic address_latch_strobe_n,
  output logic read_write,
  output logic lower_byte_enable_n,
  output logic upper_byte_enable_n,
  output logic control_oe_n,
  output logic [1:0] cycle_type_status,
  output logic status_oe_n,
  input wire logic wait_in_n,
  input wire logic [3:0] port10_in,
  output logic [3:0] port10_out,
  output logic [3:0] port10_oe_n,
  output logic system_clock_out,
  input wire logic clock_source_select,
  input wire logic [1:0] op_select_pins
);
  typedef struct packed {
    ebc_pkg::ebc_bus_t bus;
    ebc_pkg::ebc_hold_t hold;
    logic phase;
    logic clk_out;
    logic wait_hit;
    logic force_branch;
    logic [23:0] addr;
    logic write;
    logic [15:0] wdata;
    logic [1:0] kind;
    logic [15:0] ad_out;
    logic ad_oe_n;
    logic [7:0] ahi;
    logic ahi_oe_n;
    logic ctl_oe_n;
    logic data_strobe_n_n;
    logic address_latch_strobe_n_n;
    logic rw;
    logic lbe_n;
    logic ube_n;
    logic [1:0] st;
    logic st_oe_n;
    logic grant;
    logic accept;
    logic [15:0] rdata;
    logic rvalid;
    logic [1:0] power_save_control_reg;
    logic [1:0] ctrl;
    logic [7:0] reg_rdata;
  } ebc_top_state_t;

  ebc_top_state_t s;
  ebc_top_state_t next_s;

  // ********************************************************************
  // Pin synchronisers and port 10
  // ********************************************************************
  logic [`EBC_SYNC_WIDTH-1:0] sync_out;
  logic wait_sync_n;
  logic [3:0] p10_sync;
  logic [15:0] ad_sync;
  logic clock_source_select_sync;
  logic [1:0] mode_sync;
  logic [3:0] p10_read;
  logic [3:0] p10_dir;
  logic [3:0] p10_fsel;
  logic hold_req;
  logic wr_p10_data;
  logic wr_p10_dir;
  logic wr_p10_fsel;

  ebc_sync #(
    .W(`EBC_SYNC_WIDTH)
  ) u_sync (
    .clock(clock),
    .resetn(resetn),
    .din({wait_in_n, port10_in, muxed_addr_data_in, clock_source_select, op_select_pins}),
    .dout(sync_out)
  );

  assign {wait_sync_n, p10_sync, ad_sync, clock_source_select_sync, mode_sync} = sync_out;
  assign wr_p10_data = reg_write && (reg_addr == `EBC_REG_P10_DATA);
  assign wr_p10_dir = reg_write && (reg_addr == `EBC_REG_P10_DIR);
  assign wr_p10_fsel = reg_write && (reg_addr == `EBC_REG_P10_FSEL);

  ebc_port10 u_port10 (
    .clock(clock),
    .resetn(resetn),
    .wr_data(wr_p10_data),
    .wr_dir(wr_p10_dir),
    .wr_fsel(wr_p10_fsel),
    .wdata(reg_wdata[3:0]),
    .pin_sync(p10_sync),
    .grant(s.grant),
    .read_value(p10_read),
    .dir(p10_dir),
    .fsel(p10_fsel),
    .pin_out(port10_out),
    .pin_oe_n(port10_oe_n),
    .hold_req(hold_req)
  );

  // ********************************************************************
  // Bus sequencer
  // ********************************************************************
  logic bus_en;
  logic start_ok;
  logic drive_en;

  assign bus_en = (mode_sync == `EBC_MODE_ROMLESS) || s.ctrl[`EBC_CTRL_EXT_EN];
  // A pending hold blocks new cycles, so the hold wins over the core.
  assign start_ok = core_req && bus_en && !s.power_save_control_reg[`EBC_PSC_STANDBY]
                    && (s.hold == ebc_pkg::EBC_H_OFF) && !hold_req;

  always_comb begin
    next_s = s;
    next_s.accept = 1'b0;
    next_s.rvalid = 1'b0;
    next_s.reg_rdata = 8'h00;
    next_s.phase = ~s.phase;
    drive_en = 1'b0;
    if (s.phase) begin
      next_s.clk_out = ~s.power_save_control_reg[`EBC_PSC_CLK_INHIBIT];
      unique case (s.bus)
        ebc_pkg::EBC_IDLE: begin
          if (start_ok) next_s.bus = ebc_pkg::EBC_ADDR;
        end
        ebc_pkg::EBC_ADDR: begin
          next_s.bus = ebc_pkg::EBC_DATA;
        end
        ebc_pkg::EBC_DATA, ebc_pkg::EBC_WAIT: begin
          next_s.bus = s.wait_hit ? ebc_pkg::EBC_WAIT : ebc_pkg::EBC_FINAL;
        end
        ebc_pkg::EBC_FINAL: begin
          next_s.rdata = ad_sync;
          next_s.rvalid = ~s.write;
          next_s.bus = start_ok ? ebc_pkg::EBC_ADDR : ebc_pkg::EBC_IDLE;
        end
      endcase
      if (next_s.bus == ebc_pkg::EBC_ADDR) begin
        next_s.accept = 1'b1;
        next_s.addr = core_addr;
        next_s.write = core_write;
        next_s.wdata = core_wdata;
        next_s.kind = core_kind;
        if (core_kind[0] && s.force_branch) begin
          next_s.kind = `EBC_ST_BRANCH;
          next_s.force_branch = 1'b0;
        end
        next_s.ad_out = core_addr[15:0];
        next_s.ad_oe_n = 1'b0;
        next_s.ahi = core_addr[23:16];
        next_s.rw = ~core_write;
        next_s.lbe_n = (core_size == `EBC_SIZE_BYTE) && core_addr[0];
        next_s.ube_n = (core_size == `EBC_SIZE_BYTE) && !core_addr[0];
        next_s.st = next_s.kind;
        next_s.data_strobe_n_n = 1'b1;
      end else if (next_s.bus == ebc_pkg::EBC_IDLE) begin
        next_s.ad_oe_n = 1'b1;
        next_s.rw = 1'b1;
        next_s.st = `EBC_ST_IDLE;
        next_s.data_strobe_n_n = 1'b1;
        next_s.address_latch_strobe_n_n = 1'b1;
      end else if (next_s.bus == ebc_pkg::EBC_FINAL) begin
        next_s.data_strobe_n_n = 1'b1;
      end else begin
        next_s.ad_out = s.wdata;
        next_s.ad_oe_n = ~s.write;
        next_s.data_strobe_n_n = 1'b0;
      end
    end else begin
      next_s.clk_out = 1'b0;
      if (s.bus == ebc_pkg::EBC_ADDR) next_s.address_latch_strobe_n_n = 1'b0;
      if (s.bus == ebc_pkg::EBC_FINAL) next_s.address_latch_strobe_n_n = 1'b1;
      if ((s.bus == ebc_pkg::EBC_DATA) || (s.bus == ebc_pkg::EBC_WAIT)) begin
        next_s.wait_hit = ~wait_sync_n;
      end
    end
    if (core_irq_begin) next_s.force_branch = 1'b1;

    unique case (s.hold)
      ebc_pkg::EBC_H_OFF: begin
        if (hold_req && (next_s.bus == ebc_pkg::EBC_IDLE)) next_s.hold = ebc_pkg::EBC_H_FLOAT;
      end
      ebc_pkg::EBC_H_FLOAT: begin
        next_s.hold = ebc_pkg::EBC_H_ON;
        next_s.grant = 1'b1;
      end
      ebc_pkg::EBC_H_ON: begin
        if (!hold_req) begin
          next_s.hold = ebc_pkg::EBC_H_LEAVE;
          next_s.grant = 1'b0;
        end
      end
      ebc_pkg::EBC_H_LEAVE: begin
        next_s.hold = ebc_pkg::EBC_H_OFF;
      end
    endcase
    drive_en = bus_en && (next_s.hold == ebc_pkg::EBC_H_OFF);
    if (!drive_en) next_s.ad_oe_n = 1'b1;
    next_s.ahi_oe_n = ~drive_en;
    next_s.ctl_oe_n = ~drive_en;
    next_s.st_oe_n = ~(drive_en && s.ctrl[`EBC_CTRL_STATUS_EN]);

    // ********************************************************************
    // Register port
    // ********************************************************************
    if (reg_write) begin
      unique case (reg_addr)
        `EBC_REG_PSC: next_s.power_save_control_reg = reg_wdata[1:0];
        `EBC_REG_CTRL: next_s.ctrl = reg_wdata[1:0];
        default: next_s.power_save_control_reg = next_s.power_save_control_reg;
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        `EBC_REG_PSC: next_s.reg_rdata = {6'h00, s.power_save_control_reg};
        `EBC_REG_CTRL: next_s.reg_rdata = {6'h00, s.ctrl};
        `EBC_REG_P10_DATA: next_s.reg_rdata = {4'h0, p10_read};
        `EBC_REG_P10_DIR: next_s.reg_rdata = {4'h0, p10_dir};
        `EBC_REG_P10_FSEL: next_s.reg_rdata = {4'h0, p10_fsel};
        `EBC_REG_STATUS: begin
          next_s.reg_rdata = {2'h0, (s.bus != ebc_pkg::EBC_IDLE), s.grant,
                              bus_en, clock_source_select_sync, mode_sync};
        end
        default: next_s.reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.force_branch <= 1'b1;
      s.ad_oe_n <= 1'b1;
      s.ahi_oe_n <= 1'b1;
      s.ctl_oe_n <= 1'b1;
      s.data_strobe_n_n <= 1'b1;
      s.address_latch_strobe_n_n <= 1'b1;
      s.rw <= 1'b1;
      s.lbe_n <= 1'b1;
      s.ube_n <= 1'b1;
      s.st_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign reg_rdata = s.reg_rdata;
  assign core_accept = s.accept;
  assign core_rdata = s.rdata;
  assign core_rvalid = s.rvalid;
  assign muxed_addr_data_out = s.ad_out;
  assign muxed_addr_data_oe_n = s.ad_oe_n;
  assign addr_high_out = s.ahi;
  assign addr_high_oe_n = s.ahi_oe_n;
  assign data_strobe_n = s.data_strobe_n_n;
  assign address_latch_strobe_n = s.address_latch_strobe_n_n;
  assign read_write = s.rw;
  assign lower_byte_enable_n = s.lbe_n;
  assign upper_byte_enable_n = s.ube_n;
  assign control_oe_n = s.ctl_oe_n;
  assign cycle_type_status = s.st;
  assign status_oe_n = s.st_oe_n;
  assign system_clock_out = s.clk_out;
endmodule : ebc_top

// >>> verification/ebc_top_asserts.sv
// Checker for strobes, status and hold floating of the bus block.
`timescale 1ns/1ps
module ebc_top_asserts (
  input wire logic clock,
  input wire logic resetn,
  input wire logic core_accept,
  input wire logic core_rvalid,
  input wire logic muxed_addr_data_oe_n,
  input wire logic addr_high_oe_n,
  input wire logic data_strobe_n,
  input wire logic address_latch_strobe_n,
  input wire logic read_write,
  input wire logic lower_byte_enable_n,
  input wire logic upper_byte_enable_n,
  input wire logic control_oe_n,
  input wire logic [1:0] cycle_type_status,
  input wire logic [3:0] port10_out,
  input wire logic [3:0] port10_oe_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // ****************
  // Bus sequence
  // ****************
  a_ale_low_span: assert property (
    $fell(address_latch_strobe_n) |-> !address_latch_strobe_n [*4]) else $error("ale span");
  a_ale_high_gap: assert property (
    $rose(address_latch_strobe_n) |-> address_latch_strobe_n [*2]) else $error("ale gap");
  a_data_strobe_n_two_clk: assert property (
    $fell(data_strobe_n) |-> !data_strobe_n [*2]) else $error("data_strobe_n span");
  a_data_strobe_n_in_cycle: assert property (
    !data_strobe_n |-> !address_latch_strobe_n) else $error("data_strobe_n outside cycle");
  a_accept_starts: assert property (
    core_accept |-> !muxed_addr_data_oe_n && address_latch_strobe_n ##1
    !address_latch_strobe_n) else $error("accept order");
  a_rvalid_end: assert property (
    core_rvalid |-> address_latch_strobe_n && !$past(address_latch_strobe_n, 2))
    else $error("rvalid place");
  a_status_edge: assert property (
    $changed(cycle_type_status) |-> address_latch_strobe_n) else $error("status moved");
  a_rw_idle_high: assert property (
    muxed_addr_data_oe_n && address_latch_strobe_n && data_strobe_n && !control_oe_n
    |-> read_write) else $error("rw idle");
  a_be_one_low: assert property (
    !data_strobe_n |-> !(lower_byte_enable_n && upper_byte_enable_n)) else $error("be");
  a_grant_float: assert property (
    port10_out[0] && !port10_oe_n[0] |-> control_oe_n && muxed_addr_data_oe_n &&
    addr_high_oe_n) else $error("grant float");
endmodule : ebc_top_asserts

bind ebc_top ebc_top_asserts u_chk (.clock(clock), .resetn(resetn),
  .core_accept(core_accept), .core_rvalid(core_rvalid),
  .muxed_addr_data_oe_n(muxed_addr_data_oe_n), .addr_high_oe_n(addr_high_oe_n),
  .data_strobe_n(data_strobe_n), .address_latch_strobe_n(address_latch_strobe_n),
  .read_write(read_write), .lower_byte_enable_n(lower_byte_enable_n),
  .upper_byte_enable_n(upper_byte_enable_n), .control_oe_n(control_oe_n),
  .cycle_type_status(cycle_type_status), .port10_out(port10_out), .port10_oe_n(port10_oe_n));

// >>> verification/ebc_mem_model.sv
// Behavioural external memory that answers bus cycles and inserts waits.
`timescale 1ns/1ps
module ebc_mem_model (
  input wire logic clock,
  input wire logic [15:0] ad_out,
  input wire logic ad_oe_n,
  input wire logic data_strobe_n_n,
  input wire logic ale_n,
  input wire logic rw,
  input wire logic [3:0] nwait,
  output logic [15:0] ad_in,
  output logic wait_n
);
  logic [15:0] mem [int];
  logic [15:0] adr = 16'h0000;
  logic [15:0] rdw = 16'h0000;
  logic t1 = 1'b0, t2 = 1'b0, ph = 1'b0;
  int wcnt = 0;
  logic adr_ph;
  // The two-stage sampler on the wait pin needs it low from the address state on.
  assign adr_ph = !ad_oe_n && ale_n && data_strobe_n_n && !t2;
  assign wait_n = !((adr_ph && (nwait != 4'h0)) || (wcnt > 1));
  // data in read window
  // A released line toggles, so a stale word never passes for data.
  assign ad_in = (rw && (!data_strobe_n_n || t1 || t2)) ? rdw : (ph ? 16'hA5A5 : 16'h5A5A);
  always @(posedge clock) begin
    ph <= !ph;
    t1 <= !data_strobe_n_n;
    t2 <= t1;
    rdw <= mem.exists(adr[15:1]) ? mem[adr[15:1]] : ({adr[15:1], 1'b0} ^ 16'h5A3C);
    if (adr_ph) begin
      adr <= ad_out;
      wcnt <= 2 * nwait;
    end else if (wcnt > 0) begin
      wcnt <= wcnt - 1;
    end
    if (!data_strobe_n_n && !rw && !ad_oe_n) mem[adr[15:1]] = ad_out;
  end
endmodule : ebc_mem_model

// >>> verification/ebc_top_tb.sv
// Self-checking bench for the external bus control and hold block.
`timescale 1ns/1ps
module ebc_top_tb;
  logic clock = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, core_req = 1'b0;
  logic core_write = 1'b0, core_irq_begin = 1'b0, css = 1'b0, p;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, ahi;
  logic [23:0] core_addr = 24'h000000, ra;
  logic [1:0] core_size = 2'h1, core_kind = 2'h3, cts, mode = 2'h0;
  logic [15:0] core_wdata = 16'h0000, core_rdata, ad_in, ad_out;
  logic [3:0] port10_in = 4'h0, p10_out, p10_oe_n, nw = 4'h0;
  logic core_accept, core_rvalid, ad_oe_n, data_strobe_n_n, ale_n, rw, lbe_n, ube_n, coe_n, st_oe_n;
  logic wait_n, sco, ahi_oe_n;
  int miscompares = 0, checked = 0, cyc = 0, seed = 14593, fb = 1;
  int tbmem [int];
  ebc_top uut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .core_req(core_req),
    .core_write(core_write), .core_addr(core_addr), .core_size(core_size),
    .core_kind(core_kind), .core_wdata(core_wdata), .core_irq_begin(core_irq_begin),
    .core_accept(core_accept), .core_rdata(core_rdata), .core_rvalid(core_rvalid),
    .muxed_addr_data_in(ad_in), .muxed_addr_data_out(ad_out), .muxed_addr_data_oe_n(ad_oe_n),
    .addr_high_out(ahi), .addr_high_oe_n(ahi_oe_n), .data_strobe_n(data_strobe_n_n),
    .address_latch_strobe_n(ale_n), .read_write(rw), .lower_byte_enable_n(lbe_n),
    .upper_byte_enable_n(ube_n), .control_oe_n(coe_n), .cycle_type_status(cts),
    .status_oe_n(st_oe_n), .wait_in_n(wait_n), .port10_in(port10_in), .port10_out(p10_out),
    .port10_oe_n(p10_oe_n), .system_clock_out(sco), .clock_source_select(css),
    .op_select_pins(mode));
  ebc_mem_model u_mem (.clock(clock), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .data_strobe_n_n(data_strobe_n_n),
    .ale_n(ale_n), .rw(rw), .nwait(nw), .ad_in(ad_in), .wait_n(wait_n));
  always #4 clock = ~clock;
  task automatic test_done;
    $display("Checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask : wreg
  task automatic rreg(input logic [2:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    chk("reg_rdata", e, reg_rdata);
  endtask : rreg
  task automatic grant(input logic e);
    int c;
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (p10_out[0] !== e && c < 12);
    chk("grant", e, p10_out[0]);
  endtask : grant
  task automatic bus(input logic w, input logic [23:0] a, input logic [1:0] sz, k,
    input logic [15:0] d, input logic [3:0] n, input logic hq);
    int c;
    logic [15:0] e;
    e = tbmem.exists(a[15:1]) ? tbmem[a[15:1]] : ({a[15:1], 1'b0} ^ 16'h5A3C);
    nw <= n;
    core_write <= w;
    core_addr <= a;
    core_size <= sz;
    core_kind <= k;
    core_wdata <= d;
    core_req <= 1'b1;
    c = 0;
    do begin
      @(posedge clock);
      c++;
    end while (core_accept !== 1'b1 && c < 20);
    core_req <= 1'b0;
    port10_in[1] <= hq;
    chk("status", (k[0] && fb) ? 2'h1 : k, cts);
    fb = k[0] ? 0 : fb;
    chk("read_write", !w, rw);
    chk("byte_en", sz == 0 ? (a[0] ? 2'h1 : 2'h2) : 2'h0, {ube_n, lbe_n});
    chk("addr_low", a[15:0], ad_out);
    chk("addr_high", a[23:16], ahi);
    chk("ctl_drive", 0, {ahi_oe_n, coe_n});
    chk("status_oe_n", 0, st_oe_n);
    c = 0;
    if (w) begin
      tbmem[a[15:1]] = d;
      repeat (6 + 2 * n) @(posedge clock);
    end else begin
      do begin
        @(posedge clock);
        c++;
      end while (core_rvalid !== 1'b1 && c < 40);
      chk("latency", 6 + 2 * n, c);
      if (sz != 0) chk("rdata", e, core_rdata);
      chk("idle status", 0, cts);
    end
  endtask : bus
  initial begin
    css <= $random(seed);
    port10_in <= $random(seed) & 4'hD;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    chk("status_oe_n", 1, st_oe_n);
    chk("port10_oe_n", 4'hF, p10_oe_n);
    rreg(3'h3, 8'h0F);
    rreg(3'h5, {4'h0, 1'b1, css, 2'h0});
    rreg(3'h6, 8'h00);
    wreg(3'h0, 8'h01);
    repeat (3) @(posedge clock);
    chk("clk_inhibit", 0, sco);
    #2 resetn = 1'b0;
    #1 chk("reset float", 1, coe_n);
    @(posedge clock);
    resetn <= 1'b1;
    mode <= 2'h2;
    repeat (3) @(posedge clock);
    p = sco;
    @(posedge clock);
    chk("clk_toggle", !p, sco);
    rreg(3'h5, {4'h0, 1'b0, css, 2'h2});
    wreg(3'h1, 8'h03);
    rreg(3'h5, {4'h0, 1'b1, css, 2'h2});
    wreg(3'h0, 8'h02);
    core_req <= 1'b1;
    repeat (4) @(posedge clock);
    rreg(3'h5, {4'h0, 1'b1, css, 2'h2});
    core_req <= 1'b0;
    wreg(3'h0, 8'h00);
    ra = $random(seed) & 24'hFFFFFE;
    bus(0, ra, 1, 3, 0, 0, 0);
    bus(0, ra + 2, 1, 3, 0, 1, 0);
    bus(1, ra, 1, 2, $random(seed), 0, 0);
    bus(0, ra, 1, 2, 0, 2, 0);
    bus(0, ra | 1, 0, 2, 0, 0, 0);
    bus(0, ra, 0, 2, 0, 1, 0);
    core_irq_begin <= 1'b1;
    @(posedge clock);
    core_irq_begin <= 1'b0;
    fb = 1;
    bus(0, ra, 1, 3, 0, 0, 0);
    for (int i = 0; i < 8; i++) begin
      ra = $random(seed) & 24'hFFFFFE;
      bus(i % 2, ra, 1, 2 + (i % 3 == 0), $random(seed), $random(seed) & 3, 0);
    end
    wreg(3'h4, 8'h03);
    bus(0, ra, 1, 2, 0, 3, 1);
    grant(1);
    chk("ad float", 1, ad_oe_n);
    chk("ahi float", 1, ahi_oe_n);
    port10_in[1] <= 1'b0;
    grant(0);
    port10_in[1] <= 1'b1;
    grant(1);
    port10_in[1] <= 1'b0;
    grant(0);
    wreg(3'h4, 8'h00);
    wreg(3'h3, 8'hF3);
    wreg(3'h2, 8'hF4);
    chk("port10_oe_n", 4'h3, p10_oe_n);
    chk("port10_out", 2'h1, p10_out[3:2]);
    rreg(3'h2, {4'h0, 2'h1, port10_in[1:0]});
    test_done();
  end
endmodule : ebc_top_tb
